// ---- logic/adc_pkg.sv ----
// constants, types and carriers shared by the converter control logic
// assumes one clock at 250 MHz and an apb master on the register side
package adc_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SETTLE_NS = 1000; // plain default, settle time in ns
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int SAMPLE_TICKS = 2;
    localparam int STEP_TICKS = 2;
    // widths
    localparam int RES_W = 10;
    localparam int CH_W = 4;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = ADDR_W - ADDR_LSB;
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CSR = 10'h070;
    localparam logic [IDX_W-1:0] IDX_UPPER = 10'h071;
    localparam logic [IDX_W-1:0] IDX_LOWER = 10'h072;
    // control/status layout
    localparam int CSR_EOC_BIT = 7;
    localparam int CSR_SPEED_BIT = 6;
    localparam int CSR_ON_BIT = 5;
    localparam int CSR_RSVD_BIT = 4;
    localparam int CSR_CH_LSB = 0;
    localparam int REG_W = 8;
    localparam logic [REG_W-1:0] CSR_RESET = 8'h00;
    // result layout
    localparam int UPPER_LSB = 2;
    localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
    localparam logic [RES_W-1:0] SAR_FIRST = 10'h200;
    // divider terminal counts
    localparam logic [1:0] DIV_SLOW_LAST = 2'h3;
    localparam logic [1:0] DIV_FAST_LAST = 2'h1;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_SETTLE = 2'b01,
        MODE_SAMPLE = 2'b10,
        MODE_CONVERT = 2'b11
    } conv_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic [DATA_W-1:0] prdata;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic enable;
        logic sample;
        logic [CH_W-1:0] channel;
        logic [RES_W-1:0] trial;
    } afe_ctrl_t;
endpackage : adc_pkg

// ---- logic/adc_sync2.sv ----
// two flip-flop synchroniser for one asynchronous level
// assumes the input toggles slowly compared with the clock
module adc_sync2 (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // level in and out
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    // only the second stage is read; the first may be metastable
    always_comb
    begin
        d = q;
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    assign sync_out = q.s2;
endmodule : adc_sync2

// ---- logic/adc_clk_div.sv ----
// converter clock enable: one-cycle tick every four or two cpu cycles
// assumes enable and fast come from flip-flops on the same clock
module adc_clk_div (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // control
    input wire logic enable,
    input wire logic fast,
    // converter clock enable pulse
    output logic tick
);
    typedef struct packed {
        logic [1:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t q;
    div_state_t d;
    logic [1:0] last;

    // counter held at zero while off so the first tick is a full period
    always_comb
    begin
        d = q;
        last = fast ? adc_pkg::DIV_FAST_LAST : adc_pkg::DIV_SLOW_LAST;
        d.tick = 1'b0;
        if (!enable)
            d.cnt = 2'h0;
        else if (q.cnt >= last)
        begin
            // >= lets a slow-to-fast switch wrap at once
            d.cnt = 2'h0;
            d.tick = 1'b1;
        end
        else
            d.cnt = q.cnt + 2'h1;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;
endmodule : adc_clk_div

// ---- logic/sar_adc_control_logic.sv ----
// control, status and sequencing for a 10-bit successive approximation
// converter, reached over apb; drives the channel mux and the trial code
// assumes an asynchronous comparator output and same-clock power mode levels
module sar_adc_control_logic #(
    parameter int SAMPLE_TICKS = adc_pkg::SAMPLE_TICKS,
    parameter int STEP_TICKS = adc_pkg::STEP_TICKS,
    parameter int SETTLE_CYCLES = adc_pkg::SETTLE_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // register bus
    input wire adc_pkg::apb_req_t apb_req,
    output adc_pkg::apb_rsp_t apb_rsp,
    // low power modes from the system controller
    input wire logic wait_mode,
    input wire logic halt_mode,
    // analog front end
    input wire logic comp_above,
    output adc_pkg::afe_ctrl_t afe
);
    localparam int CW = adc_pkg::CH_W;
    localparam int RW = adc_pkg::RES_W;
    localparam int UL = adc_pkg::UPPER_LSB;
    localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_TICKS - 1);
    localparam logic [3:0] STEP_LAST = 4'(STEP_TICKS - 1);
    localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_CYCLES - 1);
    localparam logic [3:0] BIT_TOP = 4'(RW - 1);

    // a step must span the synchroniser latency even at the fast rate
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 16)
        $error("SAMPLE_TICKS out of range");
    if (STEP_TICKS < 2 || STEP_TICKS > 16)
        $error("STEP_TICKS out of range");
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 4096)
        $error("SETTLE_CYCLES out of range");

    typedef struct packed {
        adc_pkg::conv_mode_t mode;
        logic [3:0] tick_cnt;
        logic [3:0] bit_idx;
        logic [RW-1:0] trial;
        logic [RW-1:0] result;
        logic eoc;
        logic speed;
        logic on;
        logic [CW-1:0] ch;
        logic need_settle;
        logic [11:0] settle_cnt;
        logic afe_en;
        logic sample;
        logic pready;
        logic pslverr;
        logic [adc_pkg::DATA_W-1:0] prdata;
    } ctl_state_t;

    ctl_state_t q;
    ctl_state_t d;
    logic tick;
    logic comp_s;
    logic acc;
    logic wr;
    logic rd;
    logic hit_csr;
    logic hit_upper;
    logic hit_lower;
    logic mapped;
    logic chan_change;
    logic eoc_set;
    logic [RW-1:0] fin;

    // true when an aligned byte address selects the given register index
    function automatic logic is_reg(
        input logic [adc_pkg::ADDR_W-1:0] addr,
        input logic [adc_pkg::IDX_W-1:0] idx
    );
        is_reg = (addr[adc_pkg::ADDR_LSB-1:0] == '0)
            && (addr[adc_pkg::ADDR_W-1:adc_pkg::ADDR_LSB] == idx);
    endfunction : is_reg

    // one approximation step: drop the bit on a low compare, try the next;
    // a comparator stuck high ends at all ones, stuck low at zero
    function automatic logic [RW-1:0] sar_next(
        input logic [RW-1:0] trial,
        input logic [3:0] idx,
        input logic keep
    );
        logic [RW-1:0] t;
        t = trial;
        if (!keep)
            t[idx] = 1'b0;
        if (idx != 4'h0)
            t[4'(idx - 4'h1)] = 1'b1;
        sar_next = t;
    endfunction : sar_next

    // comparator answer crosses from the analog side
    adc_sync2 u_comp_sync (
        .clock(clock),
        .rstn(rstn),
        .async_in(comp_above),
        .sync_out(comp_s)
    );

    // converter clock enable follows the speed bit
    adc_clk_div u_div (
        .clock(clock),
        .rstn(rstn),
        .enable(q.afe_en),
        .fast(q.speed),
        .tick(tick)
    );

    // address decode and access qualification
    assign hit_csr = is_reg(apb_req.paddr, adc_pkg::IDX_CSR);
    assign hit_upper = is_reg(apb_req.paddr, adc_pkg::IDX_UPPER);
    assign hit_lower = is_reg(apb_req.paddr, adc_pkg::IDX_LOWER);
    assign mapped = hit_csr | hit_upper | hit_lower;
    assign acc = apb_req.psel & apb_req.penable & q.pready;
    assign wr = acc & apb_req.pwrite;
    assign rd = acc & ~apb_req.pwrite;
    assign chan_change = wr & hit_csr
        & (apb_req.pwdata[adc_pkg::CSR_CH_LSB +: CW] != q.ch);

    // bus slave, register file and conversion sequencer
    always_comb
    begin
        d = q;
        eoc_set = 1'b0;
        fin = sar_next(q.trial, q.bit_idx, comp_s);
        // no wait state; read data is registered during the setup phase so it comes from a flip-flop
        d.pready = apb_req.psel & ~apb_req.penable & ~q.pready;
        d.pslverr = 1'b0;
        if (d.pready)
        begin
            d.prdata = '0;
            d.pslverr = ~mapped;
            if (hit_csr)
            begin
                d.prdata[adc_pkg::CSR_EOC_BIT] = q.eoc;
                d.prdata[adc_pkg::CSR_SPEED_BIT] = q.speed;
                d.prdata[adc_pkg::CSR_ON_BIT] = q.on;
                d.prdata[adc_pkg::CSR_CH_LSB +: CW] = q.ch;
            end
            if (hit_upper)
                d.prdata[RW-UL-1:0] = q.result[RW-1:UL];
            if (hit_lower)
                d.prdata[UL-1:0] = q.result[UL-1:0];
        end
        // any control write clears the flag; other bits store, reserved bit stays zero
        if (wr && hit_csr)
        begin
            d.speed = apb_req.pwdata[adc_pkg::CSR_SPEED_BIT];
            d.on = apb_req.pwdata[adc_pkg::CSR_ON_BIT];
            d.ch = apb_req.pwdata[adc_pkg::CSR_CH_LSB +: CW];
            d.eoc = 1'b0;
        end
        if (rd && hit_upper)
            d.eoc = 1'b0;
        // sequencer; wait mode is deliberately not looked at
        unique case (q.mode)
            adc_pkg::MODE_OFF:
            begin
                d.tick_cnt = 4'h0;
                d.settle_cnt = 12'h000;
                if (q.on)
                    d.mode = q.need_settle ? adc_pkg::MODE_SETTLE
                        : adc_pkg::MODE_SAMPLE;
            end
            adc_pkg::MODE_SETTLE:
            begin
                // results are held back until the bias has settled
                d.settle_cnt = q.settle_cnt + 12'h001;
                if (q.settle_cnt == SETTLE_LAST)
                begin
                    d.mode = adc_pkg::MODE_SAMPLE;
                    d.need_settle = 1'b0;
                end
            end
            adc_pkg::MODE_SAMPLE:
            begin
                if (tick)
                begin
                    d.tick_cnt = q.tick_cnt + 4'h1;
                    if (q.tick_cnt == SAMPLE_LAST)
                    begin
                        d.mode = adc_pkg::MODE_CONVERT;
                        d.tick_cnt = 4'h0;
                        d.bit_idx = BIT_TOP;
                        d.trial = adc_pkg::SAR_FIRST;
                    end
                end
            end
            adc_pkg::MODE_CONVERT:
            begin
                if (tick)
                begin
                    d.tick_cnt = q.tick_cnt + 4'h1;
                    if (q.tick_cnt == STEP_LAST)
                    begin
                        d.tick_cnt = 4'h0;
                        d.trial = fin;
                        d.bit_idx = 4'(q.bit_idx - 4'h1);
                        if (q.bit_idx == 4'h0)
                        begin
                            d.mode = adc_pkg::MODE_SAMPLE;
                            eoc_set = 1'b1;
                        end
                    end
                end
            end
        endcase
        // power and restart overrides, strongest first
        if (halt_mode)
        begin
            d.mode = adc_pkg::MODE_OFF;
            d.need_settle = 1'b1;
            eoc_set = 1'b0;
        end
        else if (!d.on)
        begin
            d.mode = adc_pkg::MODE_OFF;
            eoc_set = 1'b0;
        end
        else if (chan_change && (q.mode == adc_pkg::MODE_SAMPLE
            || q.mode == adc_pkg::MODE_CONVERT))
        begin
            d.mode = adc_pkg::MODE_SAMPLE;
            d.tick_cnt = 4'h0;
            eoc_set = 1'b0;
        end
        // a finishing conversion beats a same-cycle clear of the flag
        if (eoc_set)
        begin
            d.result = fin;
            d.eoc = 1'b1;
        end
        d.afe_en = (d.mode != adc_pkg::MODE_OFF);
        d.sample = (d.mode == adc_pkg::MODE_SAMPLE);
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '0;
            q.mode <= adc_pkg::MODE_OFF;
            q.result <= adc_pkg::RESULT_RESET;
            {q.eoc, q.speed, q.on} <= 3'h0;
        end
        else
            q <= d;
    end

    // outputs straight from the state register
    assign apb_rsp = '{pready: q.pready, prdata: q.prdata,
        pslverr: q.pslverr};
    assign afe = '{enable: q.afe_en, sample: q.sample, channel: q.ch,
        trial: q.trial};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // flag and bus checks
    chk_upper_clear: assert property (
        rd && hit_upper && !eoc_set |=> !q.eoc)
        else $error("upper read left the flag set");
    chk_csr_write_clear: assert property (
        wr && hit_csr && !eoc_set |=> !q.eoc)
        else $error("control write left the flag set");
    chk_eoc_result: assert property (
        eoc_set |=> q.eoc && q.result == $past(fin) && afe.sample)
        else $error("finished conversion not published");
    chk_chan_restart: assert property (
        chan_change && !halt_mode && apb_req.pwdata[adc_pkg::CSR_ON_BIT]
        && q.mode == adc_pkg::MODE_CONVERT |=> afe.sample && !q.eoc)
        else $error("channel change did not restart");
    chk_channel_out: assert property (
        wr && hit_csr |=> afe.channel
        == $past(apb_req.pwdata[adc_pkg::CSR_CH_LSB +: CW]))
        else $error("channel output not updated");
    chk_off_stops: assert property (
        !q.on |=> !afe.enable)
        else $error("converter still on");
    chk_halt_off: assert property (
        halt_mode |=> !afe.enable && q.need_settle)
        else $error("halt did not stop converter");
    chk_settle_first: assert property (
        $fell(q.need_settle) |-> $past(q.mode) == adc_pkg::MODE_SETTLE)
        else $error("settle interval skipped");
    chk_wait_runs: assert property (
        wait_mode && !halt_mode && q.afe_en && q.on && !(wr && hit_csr)
        |=> afe.enable)
        else $error("wait mode disturbed converter");
    chk_tick_fast: assert property (
        tick && q.speed && q.afe_en ##1 (q.speed && q.afe_en) [*2]
        |-> tick && !$past(tick))
        else $error("fast converter clock wrong");
    chk_tick_slow: assert property (
        tick && !q.speed && q.afe_en ##1 (!q.speed && q.afe_en) [*4]
        |-> tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3))
        else $error("slow converter clock wrong");
    chk_upper_bits: assert property (
        rd && hit_upper |-> apb_rsp.prdata[RW-UL-1:0]
        == $past(q.result[RW-1:UL]))
        else $error("upper result bits wrong");
    chk_lower_pad: assert property (
        rd && hit_lower |-> apb_rsp.prdata[adc_pkg::DATA_W-1:UL] == '0)
        else $error("lower result upper bits not zero");
    chk_rsvd_zero: assert property (
        rd && hit_csr |-> !apb_rsp.prdata[adc_pkg::CSR_RSVD_BIT])
        else $error("reserved bit reads one");

    // sequencer and register content checks
    chk_start_on: assert property (
        q.on && q.mode == adc_pkg::MODE_OFF && !halt_mode
        && !(wr && hit_csr) |=> afe.enable)
        else $error("converter did not start");
    chk_trial_first: assert property (
        q.mode == adc_pkg::MODE_CONVERT
        && $past(q.mode) == adc_pkg::MODE_SAMPLE
        |-> afe.trial == adc_pkg::SAR_FIRST)
        else $error("first trial code wrong");
    chk_lower_keeps: assert property (
        rd && hit_lower && q.eoc |=> q.eoc)
        else $error("lower read cleared the flag");
    chk_speed_store: assert property (
        wr && hit_csr
        |=> q.speed == $past(apb_req.pwdata[adc_pkg::CSR_SPEED_BIT]))
        else $error("clock select not stored");
    chk_channel_read: assert property (
        rd && hit_csr |-> apb_rsp.prdata[adc_pkg::CSR_CH_LSB +: CW]
        == $past(q.ch))
        else $error("channel field reads wrong");

    // main scenarios reached
    cov_eoc: cover property (eoc_set);
    cov_restart: cover property (chan_change
        && q.mode == adc_pkg::MODE_CONVERT);
    cov_wake: cover property ($fell(q.need_settle));
    cov_fast_done: cover property (eoc_set && q.speed);
    cov_slow_done: cover property (eoc_set && !q.speed);
endmodule : sar_adc_control_logic

// ---- verif/afe_model.sv ----
// behavioural analog input mux and comparator facing the converter control
// assumes levels are codes per channel; above 3FFh is over the upper ref
module afe_model (
    // clock for the idle pattern
    input wire logic clock,
    // converter control from the design
    input wire adc_pkg::afe_ctrl_t afe,
    // per channel input level, 11 bits so that over-range can be shown
    input wire logic [15:0][10:0] levels,
    // comparator toward the design
    output logic comp_above
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk_q = 1'b0;
    logic [10:0] lvl;
    // an unpowered comparator gives no stable answer, so toggle instead
    always @(posedge clock)
    begin
        junk_q <= ~junk_q;
    end
    assign lvl = levels[afe.channel];
    // input against trial code; saturates at both references by itself
    always_comb
    begin
        if (afe.enable)
        begin
            comp_above = lvl >= {1'b0, afe.trial};
        end
        else
        begin
            comp_above = junk_q;
        end
    end
endmodule : afe_model

// ---- verif/test_sar_adc_control_logic.sv ----
// self-checking bench: apb registers, continuous conversion, channel
// change, stop, wait and halt; assumes afe_model on the analog side
module test_sar_adc_control_logic;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICKS = adc_pkg::SAMPLE_TICKS + 10 * adc_pkg::STEP_TICKS;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    adc_pkg::apb_req_t req = '0;
    adc_pkg::apb_rsp_t rsp;
    logic wait_mode = 1'b0;
    logic halt_mode = 1'b0;
    logic comp_above;
    adc_pkg::afe_ctrl_t afe;
    logic [15:0][10:0] levels = '0;
    logic [31:0] seed = 32'h0000_3756;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int compares = 0;

    sar_adc_control_logic #(.SETTLE_CYCLES(4)) u_dut (
        .clock(clock), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
        .wait_mode(wait_mode), .halt_mode(halt_mode),
        .comp_above(comp_above), .afe(afe));
    afe_model u_afe (.clock(clock), .afe(afe), .levels(levels),
        .comp_above(comp_above));

    // 250 MHz clock
    initial
    begin
        forever #2 clock = ~clock;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic print_verdict();
        if (failures == 0 && compares > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; waits for pready with a bound, never assumes it
    task automatic apb(input logic wr, input logic [9:0] idx,
        input logic [31:0] wd);
        int n;
        @(posedge clock);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= {idx, 2'b00};
        req.pwdata <= wd;
        @(posedge clock);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 50);
        if (rsp.pready !== 1'b1)
        begin
            failures++;
            print_verdict();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    // poll the completion flag, as software would
    task automatic wait_flag();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, adc_pkg::IDX_CSR, '0);
            n++;
        end
        while (rd[7] !== 1'b1 && n < 200);
        if (rd[7] !== 1'b1)
        begin
            failures++;
            print_verdict();
        end
    endtask : wait_flag

    // reference converter: ideal code, saturating at both references
    function automatic int model_code(input int lvl);
        int top;
        top = (1 << adc_pkg::RES_W) - 1;
        return (lvl > top) ? top : lvl;
    endfunction : model_code

    // lower then upper, quickly, since results are not latched
    task automatic read_result(input logic [10:0] lvl);
        int e;
        e = model_code(int'(lvl));
        apb(1'b0, adc_pkg::IDX_LOWER, '0);
        check(rd, 32'(e % 4));
        apb(1'b0, adc_pkg::IDX_UPPER, '0);
        check(rd, 32'(e / 4));
        apb(1'b0, adc_pkg::IDX_CSR, '0);
        check({31'h0, rd[7]}, '0);
    endtask : read_result

    task automatic wait_sample(input logic v, output int n);
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (afe.sample !== v && n < 500);
        if (afe.sample !== v)
        begin
            failures++;
            print_verdict();
        end
    endtask : wait_sample

    // back-to-back conversions: sample start to sample start
    task automatic measure(input int div);
        int a;
        int b;
        wait_sample(1'b0, a);
        wait_sample(1'b1, a);
        wait_sample(1'b0, a);
        wait_sample(1'b1, b);
        check(32'(a + b), 32'(TICKS * div));
    endtask : measure

    // main sequence
    initial
    begin
        logic [31:0] r;
        logic [3:0] ch;
        logic [3:0] ch2;
        logic [7:0] csr;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        check({16'h0, afe}, '0);
        apb(1'b0, adc_pkg::IDX_CSR, '0);
        check(rd, '0);
        apb(1'b0, adc_pkg::IDX_UPPER, '0);
        check(rd, '0);
        apb(1'b0, adc_pkg::IDX_LOWER, '0);
        check(rd, '0);
        apb(1'b0, 10'h073, '0);
        check({31'h0, err}, 32'h1);
        check(rd, '0);
        for (int i = 0; i < 8; i++)
        begin
            r = xs();
            ch = r[3:0];
            apb(1'b1, adc_pkg::IDX_CSR, '0);
            levels[ch] <= (i == 0) ? 11'h7FF : (i == 1) ? 11'h000 : r[14:4];
            wait_mode <= i[1];
            csr = {1'b1, i[0], 1'b1, 1'b1, ch};
            apb(1'b1, adc_pkg::IDX_CSR, {24'h0, csr});
            apb(1'b0, adc_pkg::IDX_CSR, '0);
            check(rd, {24'h0, 1'b0, i[0], 2'b10, ch});
            check({28'h0, afe.channel}, {28'h0, ch});
            wait_flag();
            read_result(levels[ch]);
            measure(i[0] ? 2 : 4);
        end
        // a write of the same value still clears a set flag
        wait_flag();
        apb(1'b1, adc_pkg::IDX_CSR, {24'h0, csr});
        apb(1'b0, adc_pkg::IDX_CSR, '0);
        check({31'h0, rd[7]}, '0);
        // channel change in mid conversion at the slow clock
        ch2 = ch + 4'h5;
        apb(1'b1, adc_pkg::IDX_CSR, '0);
        levels[ch] <= 11'h000;
        levels[ch2] <= 11'h3FF;
        apb(1'b1, adc_pkg::IDX_CSR, {24'h0, 4'h2, ch});
        repeat (30) @(posedge clock);
        apb(1'b1, adc_pkg::IDX_CSR, {24'h0, 4'h2, ch2});
        // look after the abandoned conversion would have ended, but
        // before the restarted one can end: the flag must still be clear
        repeat (70) @(posedge clock);
        apb(1'b0, adc_pkg::IDX_CSR, '0);
        check({31'h0, rd[7]}, '0);
        wait_flag();
        read_result(levels[ch2]);
        // halt stops the converter, conversion resumes after wake-up
        halt_mode <= 1'b1;
        repeat (3) @(posedge clock);
        check({31'h0, afe.enable}, '0);
        halt_mode <= 1'b0;
        wait_flag();
        read_result(levels[ch2]);
        // eight-bit use: poll, then the upper register alone
        wait_flag();
        apb(1'b0, adc_pkg::IDX_UPPER, '0);
        check(rd, 32'(model_code(int'(levels[ch2])) / 4));
        apb(1'b0, adc_pkg::IDX_CSR, '0);
        check({31'h0, rd[7]}, '0);
        // converter off: no further conversions
        apb(1'b1, adc_pkg::IDX_CSR, '0);
        repeat (200) @(posedge clock);
        check({31'h0, afe.enable}, '0);
        apb(1'b0, adc_pkg::IDX_CSR, '0);
        check(rd, '0);
        print_verdict();
    end
endmodule : test_sar_adc_control_logic
